// ---- dv/sample_fifo_modes_packing_bench.sv ----
// Bench of the sample queue: registers, modes, set selection, readout forms.
// Assumes a host model on the read port; inputs change at falling edges.
`timescale 1ns/1ps
module sample_fifo_modes_packing_bench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic measure_en = 1'b0;
  logic temp_en = 1'b0;
  logic aux_en = 1'b0;
  logic sample_valid = 1'b0;
  sfq_pkg::sfq_sample_t sample_in = '0;
  logic activity_event = 1'b0;
  logic aux_tag = 1'b0;
  logic rd_cmd_valid, rd_cmd_ready, out_valid, out_ready;
  sfq_pkg::sfq_out_t out_word;
  logic data_ready_flag, watermark_flag, overrun_flag, output_settled;
  int mismatches = 0;
  int n_checks = 0;
  int k, f;
  sfq_sample_queue #(.DEPTH(4), .SETTLE_CYCLES(20)) DUT (.*);
  sfq_host_model host (.*);
  initial forever #5 clk = ~clk;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [25:0] seen, input logic [25:0] want);
    n_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk) reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk) reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask : rd
  task automatic put(input logic [1:0] t, input logic [13:0] d);
    @(negedge clk);
    sample_valid = 1'b1;
    sample_in = {t, aux_tag, d};
    @(negedge clk) sample_valid = 1'b0;
  endtask : put
  task automatic cfg(input logic [7:0] d);
    @(negedge clk) measure_en = 1'b0;
    wr(8'h3C, d);
    @(negedge clk) measure_en = 1'b1;
  endtask : cfg
  task automatic pull(input int c, input int w);
    host.cmd(c);
    for (int i = 0; i < 40 && host.got.size() < w; i++) @(negedge clk);
  endtask : pull
  // Unused upper bytes are not defined, so only the valid bytes are compared
  function automatic logic [25:0] nxt();
    sfq_pkg::sfq_out_t w;
    if (host.got.size() == 0) return 'x;
    w = host.got.pop_front();
    return {w.nbytes, w.data & ~(24'hFFFFFF << (8 * w.nbytes))};
  endfunction : nxt
  function automatic logic [25:0] w14(input logic [15:0] s);
    return {2'h2, 8'h00, s};
  endfunction : w14
  function automatic logic [25:0] fmtw(input logic [1:0] m, input logic [15:0] s0, input logic [15:0] s1,
                                       input logic [1:0] n);
    logic [11:0] a, b;
    a = s0[13:2];
    b = s1[13:2];
    case (m)
      2'h0: return w14(s0);
      2'h1: return {2'h2, 8'h00, a[7:0], s0[15:14], {2{a[11]}}, a[11:8]};
      2'h2: return {n, 8'h00, n == 2'h2 ? s1[13:6] : 8'h00, s0[13:6]};
      default: return {n, n == 2'h3 ? b : 12'h000, a};
    endcase
  endfunction : fmtw
  initial begin
    #100us;
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    rd(8'h28, 8'h00);
    rd(8'h29, 8'h80);
    rd(8'h3C, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'h3C, 8'hF5);
    rd(8'h3C, 8'h35);
    wr(8'h3C, 8'h00);
    wr(8'h28, 8'hFE);
    rd(8'h28, 8'h06);
    wr(8'h28, 8'h02);
    wr(8'h29, 8'h03);
    @(negedge clk) measure_en = 1'b1;
    chk(output_settled, 1'b0);
    for (k = 0; k < 3; k++) put(2'(k), 14'(14'h1111 * (k + 1)));
    @(negedge clk);
    chk(watermark_flag, 1'b1);
    pull(3, 3);
    for (k = 0; k < 3; k++) chk(nxt(), w14({2'(k), 14'(14'h1111 * (k + 1))}));
    chk(watermark_flag, 1'b0);
    chk(data_ready_flag, 1'b0);
    // Settling runs 20 cycles from measurement entry; let it expire
    repeat (8) @(negedge clk);
    chk(output_settled, 1'b1);
    for (f = 1; f < 4; f++) begin
      cfg({2'h0, 2'(f), 4'h0});
      put(2'h0, 14'h2A5C);
      put(2'h1, 14'h15A3);
      pull(f == 1 ? 2 : 1, f == 1 ? 2 : 1);
      chk(nxt(), fmtw(2'(f), 16'h2A5C, 16'h55A3, 2'(2 + (f == 3))));
      if (f == 1) chk(nxt(), fmtw(2'h1, 16'h55A3, 16'h0000, 2'h2));
    end
    put(2'h2, 14'h3FFF);
    pull(1, 1);
    chk(nxt(), fmtw(2'h3, 16'hBFFF, 16'h0000, 2'h2));
    cfg(8'h00);
    wr(8'h28, 8'h01);
    for (k = 0; k < 6; k++) put(2'h0, 14'(k));
    @(negedge clk);
    chk(overrun_flag, 1'b1);
    host.stall = 1'b1;
    host.cmd(2);
    repeat (4) @(negedge clk);
    chk(rd_cmd_ready, 1'b0);
    host.stall = 1'b0;
    pull(3, 5);
    for (k = 0; k < 5; k++) chk(nxt(), w14({2'h0, 14'(k)}));
    chk(overrun_flag, 1'b0);
    put(2'h0, 14'h0ABC);
    pull(1, 1);
    chk(nxt(), w14(16'h0ABC));
    wr(8'h28, 8'h02);
    for (k = 0; k < 7; k++) put(2'h0, 14'(16 + k));
    @(negedge clk);
    chk(overrun_flag, 1'b1);
    pull(5, 5);
    for (k = 2; k < 7; k++) chk(nxt(), w14({2'h0, 14'(16 + k)}));
    wr(8'h29, 8'h02);
    wr(8'h28, 8'h03);
    for (k = 0; k < 4; k++) put(2'h0, 14'(32 + k));
    @(negedge clk) activity_event = 1'b1;
    @(negedge clk) activity_event = 1'b0;
    put(2'h0, 14'h0028);
    pull(3, 3);
    chk(nxt(), w14(16'h0022));
    chk(nxt(), w14(16'h0023));
    chk(nxt(), w14(16'h0028));
    put(2'h0, 14'h0029);
    wr(8'h28, 8'h00);
    @(negedge clk);
    chk(data_ready_flag, 1'b0);
    chk(overrun_flag, 1'b0);
    put(2'h0, 14'h0001);
    @(negedge clk);
    chk(data_ready_flag, 1'b0);
    cfg(8'h05);
    wr(8'h28, 8'h02);
    put(2'h0, 14'h0101);
    put(2'h1, 14'h0202);
    put(2'h3, 14'h0303);
    @(negedge clk) temp_en = 1'b1;
    put(2'h3, 14'h0404);
    pull(3, 2);
    repeat (4) @(negedge clk);
    chk(nxt(), w14(16'h0101));
    chk(nxt(), w14(16'hC404));
    chk(host.got.size(), 0);
    cfg(8'h29);
    put(2'h0, 14'h1234);
    aux_tag = 1'b1;
    put(2'h3, 14'h0111);
    @(negedge clk) aux_en = 1'b1;
    put(2'h3, 14'h2468);
    aux_tag = 1'b0;
    put(2'h3, 14'h0555);
    pull(1, 1);
    chk(nxt(), fmtw(2'h2, 16'h1234, 16'hE468, 2'h2));
    put(2'h0, 14'h3ABC);
    pull(1, 1);
    chk(nxt(), fmtw(2'h2, 16'h3ABC, 16'h0000, 2'h1));
    chk(host.got.size(), 0);
    complete_run();
  end
endmodule : sample_fifo_modes_packing_bench

// ---- dv/sfq_checker_assertions.sv ----
// Port checker of the sample queue: register reads, flush, readout, settling.
// Assumes it is bound to every queue instance and sees only its ports.
`timescale 1ns/1ps
module sfq_checker #(
  parameter int SETTLE_CYCLES = 20
) (
  input wire logic clk, // Clock
  input wire logic reset_n, // Async reset
  input wire logic [7:0] reg_addr, // Offset
  input wire logic reg_wr, // Write strobe
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic measure_en, // Measuring
  input wire logic sample_valid, // Sample strobe
  input wire sfq_pkg::sfq_sample_t sample_in, // Sample
  input wire logic rd_cmd_valid, // Command
  input wire logic rd_cmd_ready, // Command taken
  input wire logic out_valid, // Word valid
  input wire logic out_ready, // Word taken
  input wire sfq_pkg::sfq_out_t out_word, // Word
  input wire logic data_ready_flag, // Occupied
  input wire logic output_settled // Settled
);
  logic [1:0] mode, next_mode;
  logic [5:0] set, next_set;
  logic [8:0] wm, next_wm;
  int on_cyc, next_on_cyc;
  // Triggered mode with zero pre-event count keeps nothing before the event
  wire no_pre = mode == 2'h3 && wm == 9'h000;
  wire cmd_take = rd_cmd_valid && rd_cmd_ready;
  wire x_sel = set[3:0] inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9};
  wire x_take = sample_valid && measure_en && mode != 2'h0 && sample_in.tag == 2'h0 && x_sel && !no_pre;
  // Shadow of mode and set fields; saturating run of measuring cycles
  always_comb begin
    next_mode = mode;
    next_set = set;
    next_wm = wm;
    if (reg_wr && reg_addr == 8'h28) next_wm[8] = reg_wdata[2];
    if (reg_wr && reg_addr == 8'h29) next_wm[7:0] = reg_wdata;
    next_on_cyc = measure_en ? on_cyc + (on_cyc < 1000) : 0;
    if (reg_wr && reg_addr == 8'h28) next_mode = reg_wdata[1:0];
    if (reg_wr && reg_addr == 8'h3C) next_set = reg_wdata[5:0];
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= 2'h0;
      set <= 6'h00;
      wm <= 9'h080;
      on_cyc <= 0;
    end else begin
      mode <= next_mode;
      set <= next_set;
      wm <= next_wm;
      on_cyc <= next_on_cyc;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  unmapped_read_a: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  reserved_bits_a: assert property (reg_rd && reg_addr == 8'h28 |=> reg_rdata[7:3] == 5'h00)
    else $error("reserved control bits not zero");
  flush_disable_a: assert property (reg_wr && reg_addr == 8'h28 && reg_wdata[1:0] == 2'h0 |=> ##1 !data_ready_flag)
    else $error("queue not emptied when disabled");
  disabled_drop_a: assert property (sample_valid && mode == 2'h0 && !data_ready_flag |=> !data_ready_flag)
    else $error("sample stored while disabled");
  sample_store_a: assert property (x_take |=> data_ready_flag)
    else $error("selected sample not stored");
  word_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
    else $error("word changed before taken");
  cmd_first_a: assert property ($rose(out_valid) |-> $past(cmd_take, 2) || $past(cmd_take, 3))
    else $error("word without read command");
  tag14_size_a: assert property (out_valid && set[5:4] == 2'h0 |-> out_word.nbytes == 2'h2)
    else $error("tagged word not two bytes");
  sign_ext_a: assert property (out_valid && set[5:4] == 2'h1 |-> out_word.data[5:4] == {2{out_word.data[3]}})
    else $error("sign extension wrong");
  settle_early_a: assert property ($rose(output_settled) |-> on_cyc >= SETTLE_CYCLES - 2)
    else $error("settled too early");
  settle_late_a: assert property (on_cyc > SETTLE_CYCLES + 2 |-> output_settled)
    else $error("settled too late");
  cover property (x_take);
  cover property (out_valid && !out_ready);
  cover property (cmd_take && !data_ready_flag);
  cover property ($rose(output_settled));
endmodule : sfq_checker
bind sfq_sample_queue sfq_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.*);

// ---- dv/sfq_host_model.sv ----
// Host side of the read port: issues queue read commands, takes words.
// Assumes the design samples at rising edges; drives at falling edges.
`timescale 1ns/1ps
module sfq_host_model (
  input wire logic clk, // Clock
  input wire logic rd_cmd_ready, // Command taken
  input wire logic out_valid, // Word offered
  input wire sfq_pkg::sfq_out_t out_word, // Word
  output logic rd_cmd_valid, // Read command
  output logic out_ready // Word taken
);
  logic stall;
  sfq_pkg::sfq_out_t got[$];
  initial begin
    stall = 1'b0;
    rd_cmd_valid = 1'b0;
    out_ready = 1'b0;
  end
  // Ready is combinational on state, so its falling-edge value holds at the next rise
  task automatic cmd(input int n);
    repeat (n) begin
      @(negedge clk) rd_cmd_valid = 1'b1;
      while (!rd_cmd_ready) @(negedge clk);
      @(negedge clk) rd_cmd_valid = 1'b0;
    end
  endtask : cmd
  always @(negedge clk) begin
    if (out_valid && !stall) got.push_back(out_word);
    out_ready = !stall;
  end
endmodule : sfq_host_model

// ---- hdl/sfq_map.svh ----
// Constants of the sample queue: register offsets, field positions,
// reset values and timing figures. Definitions only.
`ifndef SFQ_MAP_SVH
`define SFQ_MAP_SVH
`define SFQ_OFS_CONTROL 8'h28
`define SFQ_OFS_WM_COUNT 8'h29
`define SFQ_OFS_SET_STRUCT 8'h3C
`define SFQ_RST_CONTROL 8'h00
`define SFQ_RST_WM_COUNT 8'h80
`define SFQ_RST_SET_STRUCT 8'h00
`define SFQ_CTL_MODE_LSB 0
`define SFQ_CTL_WM_HI_BIT 2
`define SFQ_SET_CHSEL_LSB 0
`define SFQ_SET_FMT_LSB 4
`define SFQ_DEPTH 512
`define SFQ_SETTLE_TIME_MS 100
`define SFQ_CLK_FREQ_HZ 100000000
`endif

// ---- hdl/sfq_pkg.sv ----
// Types shared by the sample queue and its bench.
// Assumes sfq_map.svh carries the numeric constants.
package sfq_pkg;
  typedef enum logic [1:0] {SFQ_DISABLED, SFQ_OLDEST, SFQ_STREAM, SFQ_TRIGGERED} sfq_mode_t;
  typedef enum logic [1:0] {SFQ_TAG14, SFQ_TAG12, SFQ_PACK8, SFQ_PACK12} sfq_fmt_t;
  typedef struct packed {
    logic [1:0] tag;   // 0 x, 1 y, 2 z, 3 temperature or aux
    logic aux;         // With tag 3: aux converter rather than temperature
    logic [13:0] data;
  } sfq_sample_t;
  typedef struct packed {
    logic [1:0] nbytes; // Valid bytes from bit 0 upward
    logic [23:0] data;
  } sfq_out_t;
endpackage : sfq_pkg

// ---- hdl/sfq_sample_queue.sv ----
// Sample queue of a motion sensor: 512-entry memory plus holding register,
// four queue modes, set selection and tagged or packed readout.
// Assumes one clock, samples arriving in set order, host reads via command port.
`timescale 1ns/1ps
`include "sfq_map.svh"
module sfq_sample_queue #(
  parameter int DEPTH = `SFQ_DEPTH,
  parameter int SETTLE_CYCLES = `SFQ_SETTLE_TIME_MS * (`SFQ_CLK_FREQ_HZ / 1000)
) (
  input wire logic clk,                         // 100 MHz sample clock
  input wire logic reset_n,                     // Power-on reset, async
  input wire logic [7:0] reg_addr,              // Register offset
  input wire logic reg_wr,                      // Register write strobe
  input wire logic [7:0] reg_wdata,             // Register write data
  input wire logic reg_rd,                      // Register read strobe
  output logic [7:0] reg_rdata,                 // Register read data
  input wire logic measure_en,                  // Measurement mode, low is standby
  input wire logic temp_en,                     // Thermal sense converter enabled
  input wire logic aux_en,                      // Aux converter enabled
  input wire logic sample_valid,                // New converter sample
  input wire sfq_pkg::sfq_sample_t sample_in,   // Converter sample
  input wire logic activity_event,              // Activity detected pulse
  input wire logic rd_cmd_valid,                // Queue read command
  output logic rd_cmd_ready,                    // Command taken
  output logic out_valid,                       // Readout word valid
  input wire logic out_ready,                   // Receiver takes word
  output sfq_pkg::sfq_out_t out_word,           // Readout word
  output logic data_ready_flag,                 // Sample in output register
  output logic watermark_flag,                  // Count at or above setting
  output logic overrun_flag,                    // Sample lost
  output logic output_settled                   // Samples past settling time
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 2;
  localparam logic [CW-1:0] CAP = CW'(DEPTH + 1);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two");
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << 24)) $error("SETTLE_CYCLES out of range");
  end

  typedef enum {F_IDLE, F_SECOND} sfq_fsm_t;

  // Registers
  logic [7:0] queue_control, next_queue_control;
  logic [7:0] watermark_count, next_watermark_count;
  logic [7:0] queue_set_structure, next_queue_set_structure;
  logic [7:0] next_reg_rdata;
  sfq_pkg::sfq_mode_t mode;
  sfq_pkg::sfq_fmt_t fmt;
  logic [3:0] chsel;
  logic [8:0] wm;

  always_comb begin
    next_queue_control = queue_control;
    next_watermark_count = watermark_count;
    next_queue_set_structure = queue_set_structure;
    next_reg_rdata = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        `SFQ_OFS_CONTROL: next_queue_control = {5'h00, reg_wdata[2:0]};
        `SFQ_OFS_WM_COUNT: next_watermark_count = reg_wdata;
        `SFQ_OFS_SET_STRUCT: next_queue_set_structure = {2'h0, reg_wdata[5:0]};
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `SFQ_OFS_CONTROL: next_reg_rdata = queue_control;
        `SFQ_OFS_WM_COUNT: next_reg_rdata = watermark_count;
        `SFQ_OFS_SET_STRUCT: next_reg_rdata = queue_set_structure;
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      queue_control <= `SFQ_RST_CONTROL;
      watermark_count <= `SFQ_RST_WM_COUNT;
      queue_set_structure <= `SFQ_RST_SET_STRUCT;
      reg_rdata <= 8'h00;
    end else begin
      queue_control <= next_queue_control;
      watermark_count <= next_watermark_count;
      queue_set_structure <= next_queue_set_structure;
      reg_rdata <= next_reg_rdata;
    end
  end

  assign mode = sfq_pkg::sfq_mode_t'(queue_control[`SFQ_CTL_MODE_LSB +: 2]);
  assign wm = {queue_control[`SFQ_CTL_WM_HI_BIT], watermark_count};
  assign chsel = queue_set_structure[`SFQ_SET_CHSEL_LSB +: 4];
  assign fmt = sfq_pkg::sfq_fmt_t'(queue_set_structure[`SFQ_SET_FMT_LSB +: 2]);

  // Set selection; source delivers x, y, z then extra, order is kept as arrived
  function automatic logic selected(input logic [3:0] cs, input sfq_pkg::sfq_sample_t s,
                                    input logic t_en, input logic a_en);
    logic axis_ok;
    logic extra_ok;
    axis_ok = (cs[1:0] == 2'h0) ? (s.tag != 2'h3) : (s.tag == cs[1:0] - 2'h1);
    extra_ok = (s.tag == 2'h3) && ((cs[3:2] == 2'h1) ? (!s.aux && t_en) : (s.aux && a_en));
    case (cs[3:2])
      2'h0: selected = axis_ok;
      2'h1, 2'h2: selected = axis_ok || extra_ok;
      default: selected = 1'b0;
    endcase
  endfunction : selected

  // Queue storage
  sfq_pkg::sfq_sample_t mem [DEPTH];
  sfq_pkg::sfq_sample_t hold, next_hold;
  logic hold_valid, next_hold_valid;
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0] mem_cnt, next_mem_cnt;
  logic trig_fired, next_trig_fired;
  logic overrun, next_overrun;
  logic [CW-1:0] count;
  logic push, full, rd_pop, discard, pop, drop, mem_wr;

  assign count = CW'(mem_cnt) + CW'(hold_valid);
  assign full = (count == CAP);
  assign push = sample_valid && measure_en && mode != sfq_pkg::SFQ_DISABLED
                && selected(chsel, sample_in, temp_en, aux_en);

  always_comb begin
    discard = 1'b0;
    drop = 1'b0;
    case (mode)
      sfq_pkg::SFQ_OLDEST: drop = full && !rd_pop;
      sfq_pkg::SFQ_STREAM: discard = full && !rd_pop;
      sfq_pkg::SFQ_TRIGGERED: begin
        if (!trig_fired) begin
          discard = (32'(count) >= 32'(wm)) && (count != '0) && !rd_pop;
          drop = (wm == 9'h000);
        end else begin
          drop = full && !rd_pop;
        end
      end
      default: drop = 1'b1;
    endcase
  end

  assign pop = rd_pop || (push && discard);

  always_comb begin
    next_hold = hold;
    next_hold_valid = hold_valid;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_mem_cnt = mem_cnt;
    mem_wr = 1'b0;
    next_trig_fired = trig_fired;
    next_overrun = overrun;
    if (pop || !hold_valid) begin
      if (mem_cnt != '0) begin
        next_hold = mem[rd_ptr];
        next_hold_valid = 1'b1;
        next_rd_ptr = rd_ptr + AW'(1);
      end else if (push && !drop) begin
        next_hold = sample_in;
        next_hold_valid = 1'b1;
      end else begin
        next_hold_valid = 1'b0;
      end
    end
    if (push && !drop && (hold_valid && !pop || mem_cnt != '0)) begin
      mem_wr = 1'b1;
      next_wr_ptr = wr_ptr + AW'(1);
    end
    next_mem_cnt = mem_cnt + (AW+1)'(mem_wr) - (AW+1)'(next_rd_ptr != rd_ptr);
    if (mode == sfq_pkg::SFQ_TRIGGERED && activity_event)
      next_trig_fired = 1'b1;
    if (rd_pop)
      next_overrun = 1'b0;
    if (push && (discard || drop) && mode != sfq_pkg::SFQ_DISABLED && !(mode == sfq_pkg::SFQ_TRIGGERED
        && !trig_fired))
      next_overrun = 1'b1;
    if (mode == sfq_pkg::SFQ_DISABLED) begin
      next_hold_valid = 1'b0;
      next_rd_ptr = '0;
      next_wr_ptr = '0;
      next_mem_cnt = '0;
      mem_wr = 1'b0;
      next_overrun = 1'b0;
    end
    if (mode != sfq_pkg::SFQ_TRIGGERED)
      next_trig_fired = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (mem_wr)
      mem[wr_ptr] <= sample_in;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold <= '0;
      hold_valid <= 1'b0;
      rd_ptr <= '0;
      wr_ptr <= '0;
      mem_cnt <= '0;
      trig_fired <= 1'b0;
      overrun <= 1'b0;
    end else begin
      hold <= next_hold;
      hold_valid <= next_hold_valid;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      mem_cnt <= next_mem_cnt;
      trig_fired <= next_trig_fired;
      overrun <= next_overrun;
    end
  end

  // Indications, registered from queue state
  logic next_wm_flag;
  assign next_wm_flag = (next_mem_cnt + (AW+1)'(next_hold_valid)) >= wm;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      watermark_flag <= 1'b0;
    end else begin
      watermark_flag <= (mode != sfq_pkg::SFQ_DISABLED || wm == 9'h000) && next_wm_flag;
    end
  end
  assign data_ready_flag = hold_valid;
  assign overrun_flag = overrun;

  // Readout formatter; nothing leaves without a read command
  sfq_fsm_t fstate, next_fstate;
  sfq_pkg::sfq_sample_t first, next_first;
  sfq_pkg::sfq_out_t emit_word, next_emit_word;
  logic emit, next_emit;
  logic [1:0] buf_cnt;
  logic cmd_take;
  logic [11:0] h12, f12;

  assign h12 = hold.data[13:2];
  assign f12 = first.data[13:2];
  assign rd_cmd_ready = fstate == F_IDLE && !emit && buf_cnt != 2'h2;
  assign cmd_take = rd_cmd_valid && rd_cmd_ready;
  assign rd_pop = (cmd_take && hold_valid) || (fstate == F_SECOND);

  always_comb begin
    next_fstate = fstate;
    next_first = first;
    next_emit = 1'b0;
    next_emit_word = emit_word;
    case (fstate)
      F_IDLE: begin
        if (cmd_take && hold_valid) begin
          next_first = hold;
          next_emit_word.data = 24'h000000;
          case (fmt)
            sfq_pkg::SFQ_TAG14: next_emit_word = {2'h2, 8'h00, hold.tag, hold.data};
            sfq_pkg::SFQ_TAG12: next_emit_word = {2'h2, 8'h00, h12[7:0], hold.tag, {2{h12[11]}}, h12[11:8]};
            sfq_pkg::SFQ_PACK8: next_emit_word = {2'h1, 16'h0000, hold.data[13:6]};
            default: next_emit_word = {2'h2, 8'h00, 4'h0, h12};
          endcase
          if ((fmt == sfq_pkg::SFQ_PACK8 || fmt == sfq_pkg::SFQ_PACK12) && count >= CW'(2))
            next_fstate = F_SECOND;
          else
            next_emit = 1'b1;
        end
      end
      F_SECOND: begin
        next_emit = 1'b1;
        next_fstate = F_IDLE;
        if (fmt == sfq_pkg::SFQ_PACK8)
          next_emit_word = {2'h2, 8'h00, hold.data[13:6], first.data[13:6]};
        else
          next_emit_word = {2'h3, h12[11:4], h12[3:0], f12[11:8], f12[7:0]};
      end
      default: next_fstate = F_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fstate <= F_IDLE;
      first <= '0;
      emit <= 1'b0;
      emit_word <= '0;
    end else begin
      fstate <= next_fstate;
      first <= next_first;
      emit <= next_emit;
      emit_word <= next_emit_word;
    end
  end

  // Two-entry buffer so a stalled receiver loses no word
  sfq_pkg::sfq_out_t obuf [2];
  logic bwp, next_bwp, brp, next_brp;
  logic [1:0] next_buf_cnt;
  logic deq;

  assign out_valid = buf_cnt != 2'h0;
  assign out_word = obuf[brp];
  assign deq = out_valid && out_ready;

  always_comb begin
    next_bwp = bwp ^ emit;
    next_brp = brp ^ deq;
    next_buf_cnt = buf_cnt + 2'(emit) - 2'(deq);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      obuf[0] <= '0;
      obuf[1] <= '0;
      bwp <= 1'b0;
      brp <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (emit)
        obuf[bwp] <= emit_word;
      bwp <= next_bwp;
      brp <= next_brp;
      buf_cnt <= next_buf_cnt;
    end
  end

  // Settling timer restarts on every entry into measurement
  logic [23:0] settle_cnt, next_settle_cnt;
  logic meas_q;

  always_comb begin
    next_settle_cnt = settle_cnt;
    if (!measure_en)
      next_settle_cnt = 24'(SETTLE_CYCLES);
    else if (settle_cnt != 24'h000000)
      next_settle_cnt = settle_cnt - 24'h000001;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_cnt <= 24'(SETTLE_CYCLES);
      meas_q <= 1'b0;
    end else begin
      settle_cnt <= next_settle_cnt;
      meas_q <= measure_en;
    end
  end
  assign output_settled = meas_q && settle_cnt == 24'h000000;

endmodule : sfq_sample_queue
